/* File: hw/mtc_cfg.svh */
// constants of the measure and test command block
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH
// direct command codes, as seen in the first byte of a frame
`define MTC_CMD_MEAS_PHASE 8'hD9
`define MTC_CMD_CLEAR_RSSI 8'hDA
`define MTC_CMD_TRANSPARENT 8'hDC
`define MTC_CMD_CAL_CAP 8'hDD
`define MTC_CMD_MEAS_CAP 8'hDE
`define MTC_CMD_MEAS_SUPPLY 8'hDF
`define MTC_CMD_TEST_ACCESS 8'hFC
// frame byte layout
`define MTC_DIRECT_TAG 2'h3
`define MTC_HDR_WRITE 2'h0
`define MTC_HDR_READ 2'h1
// test register space
`define MTC_TR_OBS_ADDR 6'h00
`define MTC_TR_OBS_RESET 8'h40
// capacitive sensor status codes
`define MTC_CS_IDLE 2'h0
`define MTC_CS_BUSY 2'h1
`define MTC_CS_DONE 2'h2
`define MTC_CS_ERROR 2'h3
// timing
`define MTC_CLK_MHZ 20
`define MTC_MEAS_US 25
`define MTC_MEAS_CYC (`MTC_MEAS_US * `MTC_CLK_MHZ)
`define MTC_CAL_MS 3
`define MTC_CAL_CYC (`MTC_CAL_MS * 1000 * `MTC_CLK_MHZ)
`define MTC_CAPM_US 250
`define MTC_CAPM_CYC (`MTC_CAPM_US * `MTC_CLK_MHZ)
`endif

/* File: hw/mtc_pkg.sv */
// types of the measure and test command block
package mtc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_PHASE, ST_SUPPLY, ST_CAL, ST_CAP} mtc_state_t;
  typedef enum logic [1:0] {LS_CMD, LS_HDR, LS_DATA} mtc_lstep_t;
  typedef struct packed {
    mtc_state_t st;
    logic [15:0] cnt;
    logic [2:0] ssl_sync;
    logic [2:0] cmd_sync;
    logic [2:0] wr_sync;
    logic trans_pend;
    logic transparent;
    logic test_access;
    logic [7:0] test_reg;
    logic [7:0] adc_result;
    logic [3:0] rssi;
    logic [1:0] cap_status;
    logic cap_irq;
    logic tx_en;
    logic det_en;
    logic adc_start;
    logic adc_rel;
    logic sup_en;
    logic [2:0] sup_sel;
    logic cal_en;
    logic meas_en;
    logic csi_test;
    logic cso_test;
    logic [3:0] obs_sel;
  } mtc_sys_t;
  typedef struct packed {
    mtc_lstep_t step;
    logic [2:0] bitcnt;
    logic [6:0] sh;
    logic test_open;
    logic acc;
    logic rd;
    logic [5:0] addr;
    logic [7:0] miso_sh;
    logic oe;
    logic [7:0] tr_s1;
    logic [7:0] tr_s2;
  } mtc_lfrm_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic cmd_tgl;
    logic [7:0] wdata;
    logic [5:0] waddr;
    logic wr_tgl;
  } mtc_lhold_t;
endpackage : mtc_pkg

/* File: hw/mtc_core.sv */
// measure, transparent and test access command block with serial link
`timescale 1ns/1ps
`include "mtc_cfg.svh"
// Overview of operation
// - phase command drives transmitter and detector, relative conversion, done in 25 us.
// - phase code 255 up to 17 deg, 0 from 163 deg, linear between.
// - each new reception clears signal strength and restarts its measurement.
// - signal strength holds the peak since last clear, ignores later decreases.
// - clear strength command clears and restarts measurement within a reception.
// - transparent command enters transparent mode at select rising edge ending frame.
// - transparent mode holds while select high; next command frame ends it.
// - sensor calibration runs only when all manual calibration bits are zero.
// - sensor interrupt only in ready mode; status shown in sensor status bits.
// - sensor calibration finishes within 3 ms.
// - capacitance measurement performs one measurement within 250 us.
// - supply command measures supply chosen by 3-bit select, stores converter result.
// - supply divided by three, absolute conversion, 23.4 mV per LSB, 25 us.
// - test access opens hidden test registers; sensor pins become test pins for observation codes 1-6 and B-E.
// - test registers reached by test access then chained auto-increment accesses.
// - test registers take default values at power-up.
// - observation register at test address 00h, read-write, default 40h.
// - observation codes 1-6 and B-E route internal signals to the two pins.
// - observation routing also works in normal operation.
module mtc_core #(
  parameter int CAL_CYC = `MTC_CAL_CYC, // sensor calibration timeout, cycles
  parameter int CAPM_CYC = `MTC_CAPM_CYC // capacitance measurement timeout, cycles
) (
  input wire logic clk_sys_i, // system clock, 20 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic spi_clk_i, // serial link clock
  input wire logic serial_select_line_i, // frame select, low inside a frame
  input wire logic spi_mosi_i, // serial data in
  output logic spi_miso_o, // serial data out
  output logic spi_miso_oe_o, // serial data out drive enable
  input wire logic rx_start_i, // pulse, new reception starts
  input wire logic [3:0] rssi_level_i, // instantaneous strength level
  input wire logic [7:0] adc_data_i, // converter code
  input wire logic adc_done_i, // pulse, conversion finished
  input wire logic [2:0] supply_select_i, // supply chosen for measurement
  input wire logic [4:0] cap_manual_cal_i, // manual calibration bits
  input wire logic ready_mode_i, // device in ready mode
  input wire logic cap_done_i, // pulse, sensor operation finished
  input wire logic cap_ok_i, // sensor operation succeeded
  output logic tx_en_o, // transmitter enable
  output logic phase_det_en_o, // phase detector enable
  output logic adc_start_o, // pulse, start conversion
  output logic adc_relative_o, // converter relative mode
  output logic supply_meas_en_o, // supply divider enable
  output logic [2:0] supply_sel_o, // supply routed to converter
  output logic [7:0] adc_result_o, // converter output register
  output logic [3:0] rssi_o, // peak-hold strength
  output logic cap_cal_en_o, // sensor calibration running
  output logic cap_meas_en_o, // sensor measurement running
  output logic [1:0] cap_status_o, // sensor status bits
  output logic cap_irq_o, // pulse, sensor calibration complete in ready mode
  output logic transparent_o, // transmitter and receiver transparent
  output logic test_access_o, // test access open in current frame
  output logic csi_test_o, // sensor input pin carries test signal
  output logic cap_sensor_out_pin_test_o, // sensor output pin carries test signal
  output logic [3:0] obs_sel_o // active observation code
);
  import mtc_pkg::*;

  localparam int MEAS_MAX = `MTC_MEAS_CYC;

  mtc_sys_t s;
  mtc_sys_t next_s;
  mtc_lfrm_t f;
  mtc_lfrm_t next_f;
  mtc_lhold_t h;
  mtc_lhold_t next_h;
  logic frame_rst_n;
  logic ssl_rise;
  logic ssl_fall;
  logic cmd_ev;
  logic wr_ev;
  logic rssi_clear;

  // codes with a listed pin assignment
  function automatic logic obs_valid(input logic [3:0] code);
    obs_valid = (code >= 4'h1 && code <= 4'h6) || (code >= 4'hB && code <= 4'hE);
  endfunction : obs_valid

  // link frame state restarts whenever select is high
  assign frame_rst_n = nrst_i & ~serial_select_line_i;

  // link side: byte assembly, command capture, test register access
  always_comb begin
    logic [7:0] rx_byte;
    rx_byte = {f.sh, spi_mosi_i};
    next_f = f;
    next_h = h;
    next_f.oe = 1'b1;
    next_f.tr_s1 = s.test_reg;
    next_f.tr_s2 = f.tr_s1;
    next_f.sh = rx_byte[6:0];
    next_f.bitcnt = f.bitcnt + 3'h1;
    next_f.miso_sh = {f.miso_sh[6:0], 1'b0};
    if (f.bitcnt == 3'h7) begin
      case (f.step)
        LS_CMD: begin
          next_f.step = LS_DATA;
          if (rx_byte[7:6] == `MTC_DIRECT_TAG) begin
            next_h.cmd = rx_byte;
            next_h.cmd_tgl = ~h.cmd_tgl;
            if (rx_byte == `MTC_CMD_TEST_ACCESS) begin
              next_f.test_open = 1'b1;
              next_f.step = LS_HDR;
            end
          end
        end
        LS_HDR: begin
          next_f.step = LS_DATA;
          next_f.addr = rx_byte[5:0];
          next_f.rd = (rx_byte[7:6] == `MTC_HDR_READ);
          next_f.acc = f.test_open && (rx_byte[7:6] == `MTC_HDR_READ ||
                                       rx_byte[7:6] == `MTC_HDR_WRITE);
          if (rx_byte[7:6] == `MTC_HDR_READ) begin
            next_f.miso_sh = (rx_byte[5:0] == `MTC_TR_OBS_ADDR) ? f.tr_s2 : 8'h00;
          end
        end
        LS_DATA: begin
          if (f.acc) begin
            next_f.addr = f.addr + 6'h01;
            if (f.rd) begin
              next_f.miso_sh = (f.addr + 6'h01 == `MTC_TR_OBS_ADDR) ? f.tr_s2 : 8'h00;
            end else begin
              next_h.wdata = rx_byte;
              next_h.waddr = f.addr;
              next_h.wr_tgl = ~h.wr_tgl;
            end
          end
        end
        default: next_f.step = LS_DATA;
      endcase
    end
  end

  // link frame registers
  always_ff @(posedge spi_clk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // link registers that carry data across frames
  always_ff @(posedge spi_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  // crossing events decoded from synchronised select and toggles
  assign ssl_rise = s.ssl_sync[1] & ~s.ssl_sync[2];
  assign ssl_fall = ~s.ssl_sync[1] & s.ssl_sync[2];
  assign cmd_ev = s.cmd_sync[1] ^ s.cmd_sync[2];
  assign wr_ev = s.wr_sync[1] ^ s.wr_sync[2];
  assign rssi_clear = rx_start_i || (cmd_ev && h.cmd == `MTC_CMD_CLEAR_RSSI);

  // system side: command execution
  always_comb begin
    next_s = s;
    next_s.ssl_sync = {s.ssl_sync[1:0], serial_select_line_i};
    next_s.cmd_sync = {s.cmd_sync[1:0], h.cmd_tgl};
    next_s.wr_sync = {s.wr_sync[1:0], h.wr_tgl};
    next_s.adc_start = 1'b0;
    next_s.cap_irq = 1'b0;
    // peak-hold strength, clear restarts from zero
    if (rssi_clear) begin
      next_s.rssi = 4'h0;
    end else if (rssi_level_i > s.rssi) begin
      next_s.rssi = rssi_level_i;
    end
    // transparent mode entry at frame end, exit on next frame
    if (cmd_ev && h.cmd == `MTC_CMD_TRANSPARENT) begin
      next_s.trans_pend = 1'b1;
    end
    if (ssl_rise && next_s.trans_pend) begin
      next_s.transparent = 1'b1;
      next_s.trans_pend = 1'b0;
    end else if (ssl_fall) begin
      next_s.transparent = 1'b0;
    end
    // test access lasts for the chained frame
    if (cmd_ev && h.cmd == `MTC_CMD_TEST_ACCESS) begin
      next_s.test_access = 1'b1;
    end else if (ssl_rise) begin
      next_s.test_access = 1'b0;
    end
    if (wr_ev && h.waddr == `MTC_TR_OBS_ADDR) begin
      next_s.test_reg = h.wdata;
    end
    // observation routing, independent of test access
    next_s.csi_test = obs_valid(next_s.test_reg[3:0]);
    next_s.cso_test = obs_valid(next_s.test_reg[3:0]);
    next_s.obs_sel = obs_valid(next_s.test_reg[3:0]) ? next_s.test_reg[3:0] : 4'h0;
    // measurement sequencer
    next_s.cnt = s.cnt + 16'h0001;
    case (s.st)
      ST_IDLE: begin
        next_s.cnt = 16'h0000;
        if (cmd_ev) begin
          case (h.cmd)
            `MTC_CMD_MEAS_PHASE: begin
              next_s.st = ST_PHASE;
              next_s.tx_en = 1'b1;
              next_s.det_en = 1'b1;
              next_s.adc_rel = 1'b1;
              next_s.adc_start = 1'b1;
            end
            `MTC_CMD_MEAS_SUPPLY: begin
              next_s.st = ST_SUPPLY;
              next_s.sup_en = 1'b1;
              next_s.sup_sel = supply_select_i;
              next_s.adc_rel = 1'b0;
              next_s.adc_start = 1'b1;
            end
            `MTC_CMD_CAL_CAP: begin
              if (cap_manual_cal_i == 5'h00) begin
                next_s.st = ST_CAL;
                next_s.cal_en = 1'b1;
                next_s.cap_status = `MTC_CS_BUSY;
              end
            end
            `MTC_CMD_MEAS_CAP: begin
              next_s.st = ST_CAP;
              next_s.meas_en = 1'b1;
              next_s.cap_status = `MTC_CS_BUSY;
            end
            default: next_s.st = ST_IDLE;
          endcase
        end
      end
      ST_PHASE, ST_SUPPLY: begin
        // give up one cycle early so the command cycle stays inside the 25 us budget
        if (adc_done_i || s.cnt == 16'(MEAS_MAX - 2)) begin
          next_s.adc_result = adc_data_i;
          next_s.st = ST_IDLE;
          next_s.tx_en = 1'b0;
          next_s.det_en = 1'b0;
          next_s.sup_en = 1'b0;
        end
      end
      ST_CAL, ST_CAP: begin
        if (cap_done_i || s.cnt == 16'(((s.st == ST_CAL) ? CAL_CYC : CAPM_CYC) - 1)) begin
          next_s.st = ST_IDLE;
          next_s.cal_en = 1'b0;
          next_s.meas_en = 1'b0;
          next_s.cap_status = (cap_done_i && cap_ok_i) ? `MTC_CS_DONE : `MTC_CS_ERROR;
          next_s.cap_irq = (s.st == ST_CAL) && ready_mode_i;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  // system registers, test register defaults at power-up
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ssl_sync <= 3'h7;
      s.test_reg <= `MTC_TR_OBS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops
  assign spi_miso_o = f.miso_sh[7];
  assign spi_miso_oe_o = f.oe;
  assign tx_en_o = s.tx_en;
  assign phase_det_en_o = s.det_en;
  assign adc_start_o = s.adc_start;
  assign adc_relative_o = s.adc_rel;
  assign supply_meas_en_o = s.sup_en;
  assign supply_sel_o = s.sup_sel;
  assign adc_result_o = s.adc_result;
  assign rssi_o = s.rssi;
  assign cap_cal_en_o = s.cal_en;
  assign cap_meas_en_o = s.meas_en;
  assign cap_status_o = s.cap_status;
  assign cap_irq_o = s.cap_irq;
  assign transparent_o = s.transparent;
  assign test_access_o = s.test_access;
  assign csi_test_o = s.csi_test;
  assign cap_sensor_out_pin_test_o = s.cso_test;
  assign obs_sel_o = s.obs_sel;

  // checks on the system side
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence seq_phase_start;
    s.st == ST_IDLE && cmd_ev && h.cmd == `MTC_CMD_MEAS_PHASE;
  endsequence
  sequence seq_back_idle;
    ##[1:MEAS_MAX] s.st == ST_IDLE;
  endsequence

  property p_phase_done;
    seq_phase_start |-> seq_back_idle;
  endproperty
  a_phase_done: assert property (p_phase_done) else $error("phase measurement overran");

  property p_phase_mode;
    s.st == ST_PHASE |-> s.tx_en && s.det_en && s.adc_rel && !s.sup_en;
  endproperty
  a_phase_mode: assert property (p_phase_mode) else $error("phase mode wrong");

  property p_supply_mode;
    s.st == ST_SUPPLY |-> !s.adc_rel && s.sup_en
      ##1 (s.st != ST_SUPPLY || $stable(s.sup_sel));
  endproperty
  a_supply_mode: assert property (p_supply_mode) else $error("supply mode wrong");

  property p_supply_store;
    s.st == ST_SUPPLY && adc_done_i |=> s.adc_result == $past(adc_data_i) && s.st == ST_IDLE;
  endproperty
  a_supply_store: assert property (p_supply_store) else $error("supply result lost");

  property p_rssi_peak;
    !rssi_clear |=> s.rssi >= $past(s.rssi);
  endproperty
  a_rssi_peak: assert property (p_rssi_peak) else $error("strength dropped");

  property p_rssi_clear;
    rssi_clear |=> s.rssi == 4'h0;
  endproperty
  a_rssi_clear: assert property (p_rssi_clear) else $error("strength not cleared");

  property p_cal_ignored;
    s.st == ST_IDLE && cmd_ev && h.cmd == `MTC_CMD_CAL_CAP && cap_manual_cal_i != 5'h00
      |=> s.st == ST_IDLE && !s.cal_en;
  endproperty
  a_cal_ignored: assert property (p_cal_ignored) else $error("manual calibration ran");

  property p_cal_bound;
    s.st == ST_CAL |-> s.cnt < 16'(CAL_CYC);
  endproperty
  a_cal_bound: assert property (p_cal_bound) else $error("calibration overran");

  property p_capm_bound;
    s.st == ST_CAP |-> s.cnt < 16'(CAPM_CYC);
  endproperty
  a_capm_bound: assert property (p_capm_bound) else $error("capacitance overran");

  property p_irq_ready;
    s.cap_irq |-> $past(ready_mode_i) && $past(s.st) == ST_CAL;
  endproperty
  a_irq_ready: assert property (p_irq_ready) else $error("irq outside ready mode");

  property p_trans_enter;
    ssl_rise && s.trans_pend |=> s.transparent [*2] or (s.transparent && ssl_fall);
  endproperty
  a_trans_enter: assert property (p_trans_enter) else $error("transparent not entered");

  property p_trans_end;
    s.transparent && ssl_fall |=> !s.transparent;
  endproperty
  a_trans_end: assert property (p_trans_end) else $error("transparent not ended");

  property p_obs_route;
    (s.cso_test == (s.test_reg[3:0] inside {[4'h1:4'h6], [4'hB:4'hE]}))
      && (s.csi_test == s.cso_test)
      && (s.obs_sel == (s.cso_test ? s.test_reg[3:0] : 4'h0));
  endproperty
  a_obs_route: assert property (p_obs_route) else $error("observation routing wrong");
endmodule : mtc_core

/* File: bench/mtc_host_model.sv */
// host model issuing serial command frames to the block
`timescale 1ns/1ps
module mtc_host_model (
  output logic spi_clk_o, // link clock, still outside frames
  output logic ssl_o, // frame select, low inside a frame
  output logic mosi_o, // data to the device
  input wire logic miso_i, // data from the device
  input wire logic miso_oe_i // device drives miso
);
  // idle link: select high, clock low
  initial begin
    spi_clk_o = 1'b0;
    ssl_o = 1'b1;
    mosi_o = 1'b0;
  end
  // n bytes msb first, the byte after the header is collected
  task automatic frame(input int n, input logic [23:0] tx, output logic [7:0] rd);
    logic [23:0] sh;
    sh = tx << (8 * (3 - n));
    rd = 8'h00;
    ssl_o = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      mosi_o = sh[23];
      sh = sh << 1;
      #62.5 spi_clk_o = 1'b1;
      #62.5 spi_clk_o = 1'b0;
      if (i >= 15 && i < 23) rd = {rd[6:0], miso_oe_i ? miso_i : 1'bx};
    end
    #62.5 ssl_o = 1'b1;
    mosi_o = ~mosi_o; // released line shows no stale value
    #250; // select stays high long enough for the device to see the frame end
  endtask : frame
endmodule : mtc_host_model

/* File: bench/tb_top.sv */
// self-checking bench of the measure and test command block
`timescale 1ns/1ps
`include "mtc_cfg.svh"
module tb_top;
  import mtc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic spi_clk, ssl, mosi, miso, miso_oe;
  logic rx_start = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [7:0] adc_data = 8'h00;
  logic adc_done = 1'b0;
  logic [2:0] sup = 3'h0;
  logic [4:0] mcal = 5'h00;
  logic ready = 1'b0;
  logic cap_done = 1'b0;
  logic cap_ok = 1'b0;
  logic tx_en, det_en, adc_start, adc_rel, sup_en, cal_en, meas_en, irq, transp, tacc;
  logic csi_t, cso_t;
  logic [2:0] sup_sel;
  logic [7:0] result, rd;
  logic [3:0] rssi, obs;
  logic [1:0] cs;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int starts = 0;
  int irqs = 0;
  int acc_cyc = 0;
  // system clock, 50 ns
  always #25 clk_sys_i = ~clk_sys_i;
  mtc_host_model i_host (.spi_clk_o(spi_clk), .ssl_o(ssl), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_i(miso_oe));
  mtc_core #(.CAL_CYC(40), .CAPM_CYC(20)) i_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .spi_clk_i(spi_clk),
    .serial_select_line_i(ssl), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .rx_start_i(rx_start), .rssi_level_i(lvl),
    .adc_data_i(adc_data), .adc_done_i(adc_done), .supply_select_i(sup),
    .cap_manual_cal_i(mcal), .ready_mode_i(ready), .cap_done_i(cap_done), .cap_ok_i(cap_ok),
    .tx_en_o(tx_en), .phase_det_en_o(det_en), .adc_start_o(adc_start),
    .adc_relative_o(adc_rel), .supply_meas_en_o(sup_en), .supply_sel_o(sup_sel),
    .adc_result_o(result), .rssi_o(rssi), .cap_cal_en_o(cal_en), .cap_meas_en_o(meas_en),
    .cap_status_o(cs), .cap_irq_o(irq), .transparent_o(transp), .test_access_o(tacc),
    .csi_test_o(csi_t), .cap_sensor_out_pin_test_o(cso_t), .obs_sel_o(obs));
  // pulse counters and hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (adc_start === 1'b1) starts++;
    if (irq === 1'b1) irqs++;
    if (tacc === 1'b1) acc_cyc++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic logic [3:0] obs_exp(input logic [3:0] c);
    return ((c >= 4'h1 && c <= 4'h6) || (c >= 4'hB && c <= 4'hE)) ? c : 4'h0;
  endfunction : obs_exp
  task automatic cmd(input logic [7:0] c);
    i_host.frame(1, {16'h0000, c}, rd);
    cyc(1);
  endtask : cmd
  // one phase or supply measurement with a given converter code
  task automatic meas(input logic [7:0] c, input logic [7:0] v, input logic rel);
    int s0;
    s0 = starts;
    adc_data = ~v;
    sup = 3'($urandom);
    cmd(c);
    for (int i = 0; i < 40 && (tx_en | sup_en) !== 1'b1; i++) cyc(1);
    chk("meas mode", {4'h0, rel, rel, rel, ~rel}, {4'h0, tx_en, det_en, adc_rel, sup_en});
    if (!rel) chk("supply sel", {5'h0, sup}, {5'h0, sup_sel});
    adc_data = v;
    adc_done = 1'b1;
    cyc(1);
    adc_done = 1'b0;
    adc_data = ~v;
    cyc(2);
    chk("meas result", v, result);
    chk("start pulses", 8'h01, 8'(starts - s0));
    chk("meas off", 8'h00, {4'h0, tx_en, det_en, sup_en, adc_start});
    $display("end meas %h", c);
  endtask : meas
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    int i0;
    logic [7:0] v;
    void'($urandom(32'h81b2));
    repeat (8) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    cyc(4);
    chk("reset outs", 8'h00, {tx_en, det_en, sup_en, cal_en, meas_en, transp, csi_t, cso_t});
    chk("reset obs", 8'h00, {obs, 2'h0, cs});
    i_host.frame(3, {`MTC_CMD_TEST_ACCESS, 8'h40, 8'h00}, rd);
    chk("test reg reset", `MTC_TR_OBS_RESET, rd);
    chk("access seen", 8'h01, {7'h0, acc_cyc > 0});
    cyc(1);
    for (int k = 0; k < 4; k++)
      meas(k[0] ? `MTC_CMD_MEAS_SUPPLY : `MTC_CMD_MEAS_PHASE,
        k == 0 ? 8'hFF : k == 1 ? 8'h00 : 8'($urandom), ~k[0]);
    // peak hold, reception restart, clear command
    lvl = 4'h9;
    cyc(2);
    lvl = 4'h3;
    cyc(2);
    chk("rssi peak", 8'h09, {4'h0, rssi});
    lvl = 4'h0;
    rx_start = 1'b1;
    cyc(1);
    rx_start = 1'b0;
    cyc(1);
    chk("rssi rx clear", 8'h00, {4'h0, rssi});
    lvl = 4'($urandom_range(15, 1));
    v = {4'h0, lvl};
    cyc(2);
    lvl = 4'h0;
    chk("rssi follow", v, {4'h0, rssi});
    cmd(`MTC_CMD_CLEAR_RSSI);
    cyc(6);
    chk("rssi cmd clear", 8'h00, {4'h0, rssi});
    $display("end rssi");
    // transparent entry at frame end, exit at next frame
    cmd(`MTC_CMD_TRANSPARENT);
    cyc(6);
    chk("transparent on", 8'h01, {7'h0, transp});
    cyc(30);
    chk("transparent hold", 8'h01, {7'h0, transp});
    cmd(`MTC_CMD_CLEAR_RSSI);
    cyc(2);
    chk("transparent off", 8'h00, {7'h0, transp});
    $display("end transparent");
    // sensor commands, host first holds the device in ready mode, then takes it out
    mcal = 5'($urandom_range(31, 1));
    ready = 1'b1;
    cmd(`MTC_CMD_CAL_CAP);
    cyc(10);
    chk("cal refused", 8'h00, {5'h0, cal_en, cs});
    mcal = 5'h00;
    i0 = irqs;
    cmd(`MTC_CMD_CAL_CAP);
    for (int i = 0; i < 40 && cal_en !== 1'b1; i++) cyc(1);
    chk("cal busy", {5'h1, `MTC_CS_BUSY}, {5'h0, cal_en, cs});
    cap_ok = 1'b1;
    cap_done = 1'b1;
    cyc(1);
    cap_done = 1'b0;
    cyc(2);
    chk("cal done", {6'h0, `MTC_CS_DONE}, {5'h0, cal_en, cs});
    chk("cal irq", 8'h01, 8'(irqs - i0));
    ready = 1'b0;
    i0 = irqs;
    cmd(`MTC_CMD_CAL_CAP);
    for (int i = 0; i < 50 && cs !== `MTC_CS_ERROR; i++) cyc(1);
    chk("cal timeout", {6'h0, `MTC_CS_ERROR}, {5'h0, cal_en, cs});
    chk("cal no irq", 8'h00, 8'(irqs - i0));
    cap_ok = 1'($urandom);
    cmd(`MTC_CMD_MEAS_CAP);
    for (int i = 0; i < 40 && meas_en !== 1'b1; i++) cyc(1);
    cap_done = 1'b1;
    cyc(1);
    cap_done = 1'b0;
    cyc(2);
    chk("cap meas", {6'h0, cap_ok ? `MTC_CS_DONE : `MTC_CS_ERROR}, {5'h0, meas_en, cs});
    $display("end sensor");
    // every observation code written and read back
    for (int k = 0; k < 16; k++) begin
      v = {4'h4, 4'(k)};
      i_host.frame(3, {`MTC_CMD_TEST_ACCESS, 8'h00, v}, rd);
      cyc(6);
      chk("obs sel", {4'h0, obs_exp(v[3:0])}, {4'h0, obs});
      chk("test pins", {6'h0, {2{obs_exp(v[3:0]) != 4'h0}}}, {6'h0, csi_t, cso_t});
      i_host.frame(3, {`MTC_CMD_TEST_ACCESS, 8'h40, 8'h00}, rd);
      chk("obs readback", v, rd);
      chk("access closed", 8'h00, {7'h0, tacc});
    end
    i_host.frame(3, {`MTC_CMD_TEST_ACCESS, 8'h01, 8'h4B}, rd);
    cyc(6);
    chk("unmapped write", 8'h00, {4'h0, obs});
    $display("end observation");
    report_and_stop();
  end
endmodule : tb_top
